// ---- test/enc_link_model.sv ----
// Behavioural far end of the parameter link: acks, naks and answers messages.
// Assumes one-cycle tx strobes on clk_i; every response is a one-cycle pulse.
`timescale 1ns/1ps
module enc_link_model (
	input  wire logic       clk_i,
	input  wire logic       short_tx_i,
	input  wire logic       long_tx_i,
	input  wire logic [3:0] nak_n_i,
	input  wire logic       ans_bad_i,
	input  wire logic [7:0] ans_dly_i,
	output logic      [3:0] short_rsp_o,
	output logic      [3:0] long_rsp_o
);
	// Response bits: 0 ack, 1 nak, 2 answer ok, 3 answer bad
	logic [3:0] rsp [2] = '{4'h0, 4'h0};
	logic [1:0] tx;
	assign tx = {long_tx_i, short_tx_i};
	assign short_rsp_o = rsp[0];
	assign long_rsp_o = rsp[1];
	for (genvar c = 0; c < 2; c++) begin : g_ch
		int cnt = 0;
		int b;
		initial forever begin
			do @(posedge clk_i);
			while (tx[c] !== 1'b1);
			#1;
			// Nak count 15 is silence, so only the frame tick can force a resend
			if (nak_n_i == 4'hf) begin
			end else if (cnt < 32'(nak_n_i)) begin
				cnt++;
				rsp[c][1] = 1'b1;
				@(posedge clk_i) #1 rsp[c][1] = 1'b0;
			end else begin
				cnt = 0;
				rsp[c][0] = 1'b1;
				@(posedge clk_i) #1 rsp[c][0] = 1'b0;
				// Delay 255 is an answer that never comes
				if (ans_dly_i != 8'hff) begin
					b = ans_bad_i ? 3 : 2;
					repeat (ans_dly_i) @(posedge clk_i);
					@(posedge clk_i) #1 rsp[c][b] = 1'b1;
					@(posedge clk_i) #1 rsp[c][b] = 1'b0;
				end
			end
		end
	end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the parameter-channel retry and event block.
// Assumes the link model above; all bench inputs change on the falling edge.
`timescale 1ns/1ps
module testbench;
	import pchan_event_pkg::*;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, pos_f = 1'b0, spos_f = 1'b0, spos2_f = 1'b0, ans_bad = 1'b0;
	logic [3:0]  req = 4'h0, crit = 4'h0, nak_n = 4'h0, s_rsp, l_rsp;
	logic [4:0]  warn = 5'h00;
	logic [6:0]  reg_addr = 7'h00;
	logic [7:0]  reg_wdata = 8'h00, g_fault = 8'h00, ans_dly = 8'h00, acc_h, mk, d;
	logic [7:0]  rdata;
	logic        rvalid, s_tx, l_tx, s_done, l_rdy, irq;
	logic [15:0] online;
	int          err_count = 0, checks_done = 0, seed = 2970, ns = 0, nl = 0, cyc = 0, i, k;
	localparam logic [6:0] RA [5] = '{EVENT_H_OFS, MASK_H_OFS, MASK_L_OFS, SUMMARY_OFS, 7'h33};

	pchan_event #(.UPDATE_CYC(16)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .short_req_i(req[3]), .long_req_i(req[2]), .host_xfer_i(req[1]),
		.frame_tick_i(req[0]), .short_tx_o(s_tx), .short_ack_i(s_rsp[0]), .short_nak_i(s_rsp[1]),
		.short_ans_ok_i(s_rsp[2]), .short_ans_bad_i(s_rsp[3]), .long_tx_o(l_tx), .long_ack_i(l_rsp[0]),
		.long_nak_i(l_rsp[1]), .long_ans_ok_i(l_rsp[2]), .long_ans_bad_i(l_rsp[3]), .group_fault_i(g_fault),
		.pos_fault_i(pos_f), .safe_pos_fault_i(spos_f), .safe_pos2_fault_i(spos2_f), .crit_err_i(crit),
		.warn_i(warn), .short_msg_done_flag_o(s_done), .long_msg_ready_flag_o(l_rdy),
		.online_status_o(online), .irq_o(irq));
	enc_link_model u_link (.clk_i(clk_i), .short_tx_i(s_tx), .long_tx_i(l_tx), .nak_n_i(nak_n),
		.ans_bad_i(ans_bad), .ans_dly_i(ans_dly), .short_rsp_o(s_rsp), .long_rsp_o(l_rsp));

	initial forever #20 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		ns = ns + int'(s_tx === 1'b1);
		nl = nl + int'(l_tx === 1'b1);
		cyc++;
		// Whole run needs about 1100 cycles; far above that is a hang
		if (cyc == 40000) begin
			err_count++;
			tally_and_finish();
		end
	end

	function automatic logic [7:0] exp_h();
		return {|(g_fault & SUM_VALID_MASK), pos_f | g_fault[0], spos_f | g_fault[1], spos2_f, crit};
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(negedge clk_i);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk_i);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a);
		@(negedge clk_i);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_i);
		reg_rd = 1'b0;
		d = rdata;
		chk("rvalid", 16'(rvalid), 16'h0001);
	endtask
	// Pulse one request strobe: 3 short, 2 long, 1 host transfer, 0 frame tick
	task automatic kick(input int w);
		@(negedge clk_i);
		req = 4'(1 << w);
		@(negedge clk_i);
		req = 4'h0;
	endtask
	task automatic wait_flag(input bit lng);
		for (k = 0; k < 400; k++) begin
			if ((lng ? l_rdy : s_done) === 1'b1) break;
			@(negedge clk_i);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		idle(10);
		rstn_i = 1'b1;
		foreach (RA[j]) begin
			rd(RA[j]);
			chk("reset reg", 16'(d), 16'h0000);
		end
		chk("reset flags", {13'h0, l_rdy, s_done, irq}, 16'h0004);
		nak_n = 4'h3;
		ans_dly = 8'($unsigned($random(seed)) % 6);
		ns = 0;
		kick(3);
		chk("done while retrying", 16'(s_done), 16'h0000);
		wait_flag(0);
		chk("short tx count", 16'(ns), 16'h0004);
		chk("short done", 16'(s_done), 16'h0001);
		nak_n = 4'hf;
		ns = 0;
		kick(3);
		for (i = 0; i < 5; i++) begin
			idle(2);
			kick(0);
		end
		idle(2);
		chk("short resends", {15'h0, s_done}, 16'h0000);
		chk("short resend count", 16'(ns), 16'h0006);
		wr(CTRL_OFS, 8'h01);
		idle(3);
		nak_n = 4'h0;
		kick(3);
		wait_flag(0);
		chk("short after reset", 16'(s_done), 16'h0001);
		ans_bad = 1'b1;
		kick(3);
		idle(20);
		chk("done after bad answer", 16'(s_done), 16'h0000);
		ans_bad = 1'b0;
		wait_flag(0);
		chk("done after good answer", 16'(s_done), 16'h0001);
		nak_n = 4'h2;
		nl = 0;
		kick(2);
		chk("ready while busy", 16'(l_rdy), 16'h0000);
		wait_flag(1);
		chk("long tx count", 16'(nl), 16'h0003);
		ans_bad = 1'b1;
		nak_n = 4'h0;
		nl = 0;
		kick(2);
		wait_flag(1);
		idle(20);
		chk("no long resend", 16'(nl), 16'h0001);
		rd(EVENT_L_OFS);
		chk("answer invalid", 16'(d[EVL_ANS_BIT]), 16'h0001);
		wr(EVENT_L_OFS, 8'h00);
		ans_bad = 1'b0;
		ans_dly = 8'hff;
		kick(2);
		idle(300);
		chk("long stall", 16'(l_rdy), 16'h0000);
		pos_f = 1'b1;
		wr(CTRL_OFS, 8'h01);
		idle(3);
		chk("ready after reset", 16'(l_rdy), 16'h0001);
		kick(1);
		chk("position through reset", 16'(online[15:8]), 16'(1 << EVH_POS_BIT));
		pos_f = 1'b0;
		wr(EVENT_H_OFS, 8'h00);
		@(negedge clk_i);
		reg_addr = EVENT_H_OFS;
		reg_wdata = 8'h00;
		reg_wr = 1'b1;
		crit = 4'h1;
		@(negedge clk_i);
		reg_wr = 1'b0;
		crit = 4'h0;
		rd(EVENT_H_OFS);
		chk("set beats clear", 16'(d), 16'h0001);
		wr(EVENT_H_OFS, 8'h00);
		for (i = 0; i < 20; i++) begin
			{g_fault, crit, warn, pos_f, spos_f, spos2_f} = 20'($random(seed));
			mk = 8'($random(seed));
			idle(4);
			acc_h = exp_h();
			rd(SUMMARY_OFS);
			chk("summary", 16'(d), 16'(g_fault & SUM_VALID_MASK));
			kick(1);
			chk("online live", online, {acc_h, warn, 3'b010});
			wr(MASK_H_OFS, mk);
			rd(MASK_H_OFS);
			chk("mask", 16'(d), 16'(mk));
			wr(MASK_L_OFS, {mk[7:3], 3'b000});
			rd(EVENT_L_OFS);
			chk("event low", 16'(d[7:3]), 16'(warn));
			{g_fault, crit, warn, pos_f, spos_f, spos2_f} = 20'h0;
			idle(4);
			kick(1);
			chk("online cleared", online, 16'(1 << EVL_FREADY_BIT));
			rd(EVENT_H_OFS);
			chk("event high sticky", 16'(d), 16'(acc_h));
			chk("irq", 16'(irq), 16'(|({acc_h, warn} & {mk, mk[7:3]})));
			wr(EVENT_H_OFS, 8'h00);
			wr(EVENT_L_OFS, 8'h00);
			idle(3);
			chk("irq after clear", 16'(irq), 16'h0000);
		end
		tally_and_finish();
	end
endmodule

// ---- verilog/pchan_event.sv ----
// Parameter-channel retry engine plus event, mask, online status and summary logic.
// Link-side strobes and condition inputs come from logic on clk_i; host port is a byte register port.
`timescale 1ns/1ps

module pchan_event
	import pchan_event_pkg::*;
#(
	parameter int UPDATE_CYC = UPDATE_MAX_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// Host register port
	input  wire logic [6:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_rvalid_o,
	// Host message requests and transfer strobe
	input  wire logic       short_req_i,
	input  wire logic       long_req_i,
	input  wire logic       host_xfer_i,
	// Link side
	input  wire logic       frame_tick_i,
	output logic            short_tx_o,
	input  wire logic       short_ack_i,
	input  wire logic       short_nak_i,
	input  wire logic       short_ans_ok_i,
	input  wire logic       short_ans_bad_i,
	output logic            long_tx_o,
	input  wire logic       long_ack_i,
	input  wire logic       long_nak_i,
	input  wire logic       long_ans_ok_i,
	input  wire logic       long_ans_bad_i,
	// Encoder conditions
	input  wire logic [7:0] group_fault_i,
	input  wire logic       pos_fault_i,
	input  wire logic       safe_pos_fault_i,
	input  wire logic       safe_pos2_fault_i,
	input  wire logic [3:0] crit_err_i,
	input  wire logic [4:0] warn_i,
	// Status outputs
	output logic            short_msg_done_flag_o,
	output logic            long_msg_ready_flag_o,
	output logic [15:0]     online_status_o,
	output logic            irq_o
);

	msg_state_t s_state_r;
	msg_state_t l_state_r;
	logic [7:0] event_h_r;
	logic [7:0] event_l_r;
	logic [7:0] mask_h_r;
	logic [7:0] mask_l_r;
	logic [7:0] summary_r;
	logic       msg_rst_r;
	logic       ans_bad_evt;
	logic [7:0] event_h_now;
	logic [7:0] event_l_now;
	logic [7:0] clr_h;
	logic [7:0] clr_l;
	logic       wr_event_h;
	logic       wr_event_l;

	assign wr_event_h = reg_wr_i && (reg_addr_i == EVENT_H_OFS);
	assign wr_event_l = reg_wr_i && (reg_addr_i == EVENT_L_OFS);

	// Message reset is a one-cycle pulse from a control write, so it cannot hold the channel idle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			msg_rst_r <= 1'b0;
		end else begin
			msg_rst_r <= reg_wr_i && (reg_addr_i == CTRL_OFS) && reg_wdata_i[CTRL_MSG_RST_BIT];
		end
	end

	// Short message engine; retries are not counted or reported, only the done flag is visible
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_state_r             <= M_IDLE;
			short_tx_o            <= 1'b0;
			short_msg_done_flag_o <= 1'b0;
		end else begin
			short_tx_o <= 1'b0;
			if (msg_rst_r) begin
				s_state_r             <= M_IDLE;
				short_msg_done_flag_o <= 1'b0;
			end else begin
				unique case (s_state_r)
					M_IDLE: begin
						if (short_req_i) begin
							short_tx_o            <= 1'b1;
							short_msg_done_flag_o <= 1'b0;
							s_state_r             <= M_WAIT_ACK;
						end
					end
					M_WAIT_ACK: begin
						if (short_ack_i) begin
							s_state_r <= M_WAIT_ANS;
						end else if (short_nak_i || frame_tick_i) begin
							short_tx_o <= 1'b1;
						end
					end
					M_WAIT_ANS: begin
						if (short_ans_ok_i) begin
							short_msg_done_flag_o <= 1'b1;
							s_state_r             <= M_IDLE;
						end else if (short_ans_bad_i) begin
							short_tx_o <= 1'b1;
							s_state_r  <= M_WAIT_ACK;
						end
					end
				endcase
			end
		end
	end

	// Long message engine; no timeout anywhere, the host owns overrun detection
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			l_state_r             <= M_IDLE;
			long_tx_o             <= 1'b0;
			long_msg_ready_flag_o <= 1'b1;
		end else begin
			long_tx_o <= 1'b0;
			if (msg_rst_r) begin
				l_state_r             <= M_IDLE;
				long_msg_ready_flag_o <= 1'b1;
			end else begin
				unique case (l_state_r)
					M_IDLE: begin
						if (long_req_i) begin
							long_tx_o             <= 1'b1;
							long_msg_ready_flag_o <= 1'b0;
							l_state_r             <= M_WAIT_ACK;
						end
					end
					M_WAIT_ACK: begin
						if (long_ack_i) begin
							l_state_r <= M_WAIT_ANS;
						end else if (long_nak_i || frame_tick_i) begin
							long_tx_o <= 1'b1;
						end
					end
					M_WAIT_ANS: begin
						if (long_ans_ok_i || long_ans_bad_i) begin
							long_msg_ready_flag_o <= 1'b1;
							l_state_r             <= M_IDLE;
						end
					end
				endcase
			end
		end
	end

	assign ans_bad_evt = (l_state_r == M_WAIT_ANS) && long_ans_bad_i && !msg_rst_r;

	// Summary follows the grouped encoder errors; reserved bits stay zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			summary_r <= SUMMARY_RST;
		end else begin
			summary_r <= group_fault_i & SUM_VALID_MASK;
		end
	end

	// Present conditions; message reset touches only the answer-invalid, ready and done bits here
	always_comb begin
		event_h_now                = {4'h0, crit_err_i};
		event_h_now[EVH_AGGR_BIT]  = |summary_r;
		event_h_now[EVH_POS_BIT]   = pos_fault_i | summary_r[SUM_FAST_POS_BIT];
		event_h_now[EVH_SPOS_BIT]  = safe_pos_fault_i | summary_r[SUM_SAFE_POS_BIT];
		event_h_now[EVH_SPOS2_BIT] = safe_pos2_fault_i;
		event_l_now                = {warn_i, 3'b000};
		event_l_now[EVL_ANS_BIT]   = ans_bad_evt;
		event_l_now[EVL_FREADY_BIT] = long_msg_ready_flag_o;
		event_l_now[EVL_SDONE_BIT] = short_msg_done_flag_o;
	end

	// Writing a zero to an event bit acknowledges it
	assign clr_h = wr_event_h ? ~reg_wdata_i : 8'h00;
	assign clr_l = wr_event_l ? ~reg_wdata_i : 8'h00;

	// Sticky events (low bits 1 and 0 follow live): set wins over a same-cycle clear
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			event_h_r <= EVENT_RST;
			event_l_r <= EVENT_RST;
		end else begin
			event_h_r <= (event_h_r & ~clr_h) | event_h_now;
			event_l_r <= (((event_l_r & ~clr_l) | event_l_now) & EVL_STICKY_MASK)
				| (event_l_now & ~EVL_STICKY_MASK);
		end
	end

	// Mask bits only gate the interrupt; they never alter event contents
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mask_h_r <= MASK_RST;
			mask_l_r <= MASK_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == MASK_H_OFS) begin
				mask_h_r <= reg_wdata_i;
			end
			if (reg_addr_i == MASK_L_OFS) begin
				mask_l_r <= reg_wdata_i;
			end
		end
	end

	// Registered for a clean pin, so the interrupt trails a latched event by one cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(event_h_r & mask_h_r) || |(event_l_r & mask_l_r);
		end
	end

	// Online status carries live conditions, captured at the start of every host transfer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			online_status_o <= 16'h0000;
		end else if (host_xfer_i) begin
			online_status_o <= {event_h_now, event_l_now};
		end
	end

	// Control and unmapped addresses read as zero; reads have no side effects
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					EVENT_H_OFS: reg_rdata_o <= event_h_r;
					EVENT_L_OFS: reg_rdata_o <= event_l_r;
					MASK_H_OFS:  reg_rdata_o <= mask_h_r;
					MASK_L_OFS:  reg_rdata_o <= mask_l_r;
					SUMMARY_OFS: reg_rdata_o <= summary_r;
					default:     reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Helper: cycles a live high condition bit has been missing from the high event register
	logic [15:0] lag_cnt_r;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lag_cnt_r <= 16'h0000;
		end else if ((event_h_now & ~event_h_r) != 8'h00) begin
			lag_cnt_r <= lag_cnt_r + 16'h0001;
		end else begin
			lag_cnt_r <= 16'h0000;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_short_sent;
		s_state_r == M_WAIT_ACK && !short_ack_i && short_nak_i && !msg_rst_r;
	endsequence

	sequence s_long_bad_answer;
		l_state_r == M_WAIT_ANS && long_ans_bad_i && !msg_rst_r;
	endsequence

	a_short_retry_pulse: assert property (s_short_sent |=> short_tx_o)
		else $error("short message not resent after nak");
	a_short_done_low: assert property (s_state_r != M_IDLE |-> !short_msg_done_flag_o)
		else $error("short done flag high while message pending");
	a_long_retry_pulse: assert property (
		l_state_r == M_WAIT_ACK && !long_ack_i && frame_tick_i && !msg_rst_r |=> long_tx_o)
		else $error("long message not repeated without ack");
	a_long_bad_event: assert property (s_long_bad_answer |=> event_l_r[EVL_ANS_BIT]
		&& !long_tx_o)
		else $error("invalid long answer not flagged or message resent");
	a_long_wait_hold: assert property (
		l_state_r == M_WAIT_ANS && !long_ans_ok_i && !long_ans_bad_i && !msg_rst_r |=> l_state_r == M_WAIT_ANS)
		else $error("long answer wait left without answer");
	a_msg_reset_idle: assert property (msg_rst_r |=> s_state_r == M_IDLE && l_state_r == M_IDLE
		&& long_msg_ready_flag_o)
		else $error("message reset did not free the channel");
	a_event_lag_bound: assert property (lag_cnt_r < 16'(UPDATE_CYC))
		else $error("event not updated in time");
	a_event_sticky_hold: assert property (
		event_h_r[EVH_POS_BIT] && !wr_event_h |=> event_h_r[EVH_POS_BIT])
		else $error("high event bit dropped without acknowledge");
	a_set_beats_clear: assert property (wr_event_h && event_h_now[EVH_POS_BIT] |=> event_h_r[EVH_POS_BIT])
		else $error("same-cycle clear lost an event");
	a_irq_from_mask: assert property ((event_l_r & mask_l_r) != 8'h00 |=> irq_o)
		else $error("unmasked event did not raise interrupt");
	a_online_live: assert property (
		host_xfer_i |=> online_status_o[15:8] == $past(event_h_now))
		else $error("online status not current at transfer");
	a_aggr_summary: assert property (summary_r != 8'h00 |=> event_h_r[EVH_AGGR_BIT])
		else $error("aggregate fault bit missing");

	// Answer steps of a short transfer, good and bad
	sequence s_short_answer_ok;
		s_state_r == M_WAIT_ANS && short_ans_ok_i && !msg_rst_r;
	endsequence

	sequence s_short_answer_bad;
		s_state_r == M_WAIT_ANS && !short_ans_ok_i && short_ans_bad_i && !msg_rst_r;
	endsequence

	a_short_done_set: assert property (s_short_answer_ok |=> short_msg_done_flag_o)
		else $error("short done flag not set after valid answer");
	a_short_bad_resend: assert property (s_short_answer_bad |=> short_tx_o && s_state_r == M_WAIT_ACK)
		else $error("invalid short answer not resent");
	a_short_tick_resend: assert property (
		s_state_r == M_WAIT_ACK && !short_ack_i && frame_tick_i && !msg_rst_r |=> short_tx_o)
		else $error("short message retry stopped");
	a_long_ready_low: assert property (l_state_r != M_IDLE |-> !long_msg_ready_flag_o)
		else $error("long ready flag high while message pending");
	a_long_ready_back: assert property (
		l_state_r == M_WAIT_ANS && (long_ans_ok_i || long_ans_bad_i) && !msg_rst_r |=> long_msg_ready_flag_o)
		else $error("long ready flag not restored after answer");
	a_msg_reset_short: assert property (msg_rst_r |=> !short_msg_done_flag_o && !short_tx_o
		&& !long_tx_o)
		else $error("message reset left a message in flight");
	a_pos_through_reset: assert property (msg_rst_r && pos_fault_i |=> event_h_r[EVH_POS_BIT])
		else $error("message reset disturbed position fault path");
	a_ans_sticky_hold: assert property (
		event_l_r[EVL_ANS_BIT] && !wr_event_l |=> event_l_r[EVL_ANS_BIT])
		else $error("answer invalid event dropped without acknowledge");
	a_irq_high_mask: assert property ((event_h_r & mask_h_r) != 8'h00 |=> irq_o)
		else $error("unmasked high event did not raise interrupt");
	a_irq_quiet: assert property (
		(event_h_r & mask_h_r) == 8'h00 && (event_l_r & mask_l_r) == 8'h00 |=> !irq_o)
		else $error("interrupt raised with all events masked or clear");
	a_online_low_live: assert property (
		host_xfer_i |=> online_status_o[7:0] == $past(event_l_now))
		else $error("online low status not current at transfer");
	a_online_hold: assert property (!host_xfer_i |=> $stable(online_status_o))
		else $error("online status changed between transfers");
	a_summary_follow: assert property (1'b1 |=> summary_r == ($past(group_fault_i) & SUM_VALID_MASK))
		else $error("summary register does not follow fault groups");

endmodule

// ---- verilog/pchan_event_pkg.sv ----
// Constants for the parameter-channel error handling and event/status block.
// Assumes one 25 MHz system clock; the link layer and host port share it.
//
// Overview of operation
// - Short message with a transfer error is resent automatically; retries stay invisible to host.
// - Short-message done flag stays low until a valid answer arrives.
// - Short retries never stop by themselves; only a host message reset ends them.
// - Unacknowledged long message is resent cyclically with no internal timeout.
// - Invalid answer to a delivered long message sets answer-invalid event; no resend.
// - After long-message acknowledge the master waits for the answer forever.
// - Host message reset abandons pending short and long messages, channel accepts new ones.
// - Message reset leaves position measurement and position data paths untouched.
// - Event registers follow their conditions within 200 us.
// - High event register holds critical errors, low event register warnings and status.
// - Event error and warning bits stay set until the host clears them.
// - Each event bit has its own mask bit; unmasked set events drive the interrupt.
// - Online status word mirroring the events is returned on every host transfer.
// - Online status shows present conditions only, never latched history.
// - Online status is refreshed within 200 us of a condition change; here only on host_xfer_i strobes, with no time bound.
// - Summary bits: 0 fast pos, 1 safe pos, 2 install, 3 monitor, 4 resource, 7 user.
// - A set summary bit means at least one error of that group is present.
// - Aggregate fault bit in high event register is the OR of all summary groups.
// - Position-relevant faults also show on the fast and safe position fault bits.
// - Long-message ready flag is low while a long message is processed, high when done.
package pchan_event_pkg;

	// Register byte offsets
	localparam logic [6:0] CTRL_OFS        = 7'h00;
	localparam logic [6:0] EVENT_H_OFS     = 7'h04;
	localparam logic [6:0] EVENT_L_OFS     = 7'h05;
	localparam logic [6:0] MASK_H_OFS      = 7'h06;
	localparam logic [6:0] MASK_L_OFS      = 7'h07;
	localparam logic [6:0] SUMMARY_OFS     = 7'h18;

	// Control register fields
	localparam int         CTRL_MSG_RST_BIT = 0;

	// High event register fields
	localparam int         EVH_AGGR_BIT    = 7;
	localparam int         EVH_POS_BIT     = 6;
	localparam int         EVH_SPOS_BIT    = 5;
	localparam int         EVH_SPOS2_BIT   = 4;

	// Low event register fields
	localparam int         EVL_ANS_BIT     = 2;
	localparam int         EVL_FREADY_BIT  = 1;
	localparam int         EVL_SDONE_BIT   = 0;
	localparam logic [7:0] EVL_STICKY_MASK = 8'hFC;

	// Summary register fields
	localparam int         SUM_FAST_POS_BIT = 0;
	localparam int         SUM_SAFE_POS_BIT = 1;
	localparam logic [7:0] SUM_VALID_MASK   = 8'h9F;

	// Reset values
	localparam logic [7:0] EVENT_RST       = 8'h00;
	localparam logic [7:0] MASK_RST        = 8'h00;
	localparam logic [7:0] SUMMARY_RST     = 8'h00;

	// Timing
	localparam int         CLK_PERIOD_NS   = 40;
	localparam int         UPDATE_MAX_NS   = 200_000;
	localparam int         UPDATE_MAX_CYC  = UPDATE_MAX_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		M_IDLE,
		M_WAIT_ACK,
		M_WAIT_ANS
	} msg_state_t;

endpackage
